// ### src/bms_consts.vh
// constants for the boot mode select block
`ifndef BMS_CONSTS_VH
`define BMS_CONSTS_VH
`define BMS_MODE_NONE      3'h0
`define BMS_MODE_HOST      3'h1
`define BMS_MODE_LINK      3'h2
`define BMS_MODE_EPROM     3'h3
`define BMS_MODE_RSVD      3'h4
`define BMS_ADDR_CTRL      12'h000
`define BMS_ADDR_STATUS    12'h004
`define BMS_ADDR_STRAP     12'h008
`define BMS_ADDR_CYCLES    12'h00C
`define BMS_CTRL_MASTER    0
`define BMS_CTRL_CS        1
`define BMS_CTRL_RUN       2
`define BMS_CTRL_RESET     32'h00000000
`define BMS_ST_MODE_LSB    0
`define BMS_ST_LATCHED     4
`define BMS_ST_OE          5
`define BMS_ST_EXTMEM      6
`define BMS_ST_WIDTH8      7
`define BMS_ST_LINKPORT    8
`define BMS_EPROM_WIDTH    4'h8
`define BMS_ZERO32         32'h00000000
`endif

// ### src/bms_decode.v
// strap decoder: three strap levels to boot mode code
`timescale 1ns/10ps
module bms_decode (
  eprom_boot_level,
  link_boot_level,
  boot_memory_select,
  mode
);
  `include "bms_consts.vh"
  input  wire       eprom_boot_level;
  input  wire       link_boot_level;
  input  wire       boot_memory_select;
  output reg  [2:0] mode;

  always @* begin
    mode = `BMS_MODE_RSVD;
    case ({eprom_boot_level, link_boot_level, boot_memory_select})
      3'h4, 3'h5: mode = `BMS_MODE_EPROM; // RL1
      3'h1:       mode = `BMS_MODE_HOST; // RL1
      3'h3:       mode = `BMS_MODE_LINK; // RL1
      3'h0:       mode = `BMS_MODE_NONE; // RL1
      default:    mode = `BMS_MODE_RSVD; // RL1
    endcase
  end
endmodule

// ### src/bms_top.v
// boot mode select for the shared-strap processors, with apb status and control
// Summary of operation
// RL1: decode eprom, link, select straps into mode
// RL2: eprom mode drives select pin as chip select
// RL3: select sampled low means no boot, external memory; here only with the eprom and link straps both low
// RL4: only the bus master drives the select output
// RL5: select pin tristatable only in eprom mode
// RL6: system hardwires the select strap level
// RL7: active low reset at power-up gives known state
// RL8: one instruction per input clock cycle
// RL9: input clock never stops or changes rate
// RL10: eprom strap high boots from 8-bit eprom; here only with the link strap low, both high decode as reserved
// RL11: link strap high boots through link port; here only with eprom strap low and select high, else reserved
// RL12: straps sampled in reset, mode held afterward; here sampled at the first pclk edge after reset release
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module bms_top (
  pclk,
  presetn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  eprom_boot_strap,
  link_boot_strap,
  boot_memory_select_in,
  boot_memory_select_out,
  boot_memory_select_oe,
  boot_mode,
  boot_from_eprom,
  boot_from_link,
  boot_from_host,
  run_external,
  instr_step
);
  `include "bms_consts.vh"
  input  wire        pclk;
  input  wire        presetn;
  input  wire        psel;
  input  wire        penable;
  input  wire        pwrite;
  input  wire [11:0] paddr;
  input  wire [31:0] pwdata;
  output reg  [31:0] prdata;
  output reg         pready;
  output reg         pslverr;
  input  wire        eprom_boot_strap;
  input  wire        link_boot_strap;
  input  wire        boot_memory_select_in;
  output reg         boot_memory_select_out;
  output reg         boot_memory_select_oe;
  output reg  [2:0]  boot_mode;
  output reg         boot_from_eprom;
  output reg         boot_from_link;
  output reg         boot_from_host;
  output reg         run_external;
  output reg         instr_step;

  wire [2:0]  strap_mode;
  wire        access;
  wire        setup;
  wire        wr_ctrl;
  reg         latched;
  reg  [2:0]  strap_bits;
  reg  [31:0] ctrl;
  reg  [31:0] cycles;
  reg  [31:0] next_prdata;
  reg         next_slverr;
  reg         next_latched;
  reg  [2:0]  next_boot_mode;
  reg  [2:0]  next_strap_bits;
  reg  [31:0] next_ctrl;
  reg  [31:0] next_cycles;
  reg         pin_drive;
  reg         run_enable;

  function is_eprom;
    input [2:0] m;
    begin
      is_eprom = (m == `BMS_MODE_EPROM);
    end
  endfunction

  function mode_is;
    input [2:0] m;
    input [2:0] code;
    begin
      mode_is = (m == code);
    end
  endfunction

  bms_decode u_decode (
    .eprom_boot_level   (eprom_boot_strap),
    .link_boot_level    (link_boot_strap),
    .boot_memory_select (boot_memory_select_in),
    .mode               (strap_mode)
  );

  assign access  = psel & penable;
  assign setup   = psel & ~penable;
  assign wr_ctrl = access & pwrite & (paddr == `BMS_ADDR_CTRL);

  // the async clear may only load constants, so the straps are taken at the
  // first edge after release and then frozen until the next reset
  always @* begin
    next_latched    = latched;
    next_boot_mode  = boot_mode;
    next_strap_bits = strap_bits;
    if (!latched) begin
      next_latched    = 1'b1; // RL12
      next_boot_mode  = strap_mode; // RL12
      next_strap_bits = {eprom_boot_strap, link_boot_strap, boot_memory_select_in};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched <= 1'b0; // RL7
    end else begin
      latched <= next_latched;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_mode <= `BMS_MODE_NONE; // RL7
    end else begin
      boot_mode <= next_boot_mode;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_bits <= `BMS_MODE_NONE;
    end else begin
      strap_bits <= next_strap_bits;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_from_eprom <= 1'b0;
    end else begin
      boot_from_eprom <= latched & is_eprom(boot_mode); // RL10
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_from_link <= 1'b0;
    end else begin
      boot_from_link <= latched & mode_is(boot_mode, `BMS_MODE_LINK); // RL11
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_from_host <= 1'b0;
    end else begin
      boot_from_host <= latched & mode_is(boot_mode, `BMS_MODE_HOST); // RL1
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_external <= 1'b0;
    end else begin
      run_external <= latched & mode_is(boot_mode, `BMS_MODE_NONE); // RL3
    end
  end

  // pin is driven only in eprom mode and only by the current bus master
  always @* begin
    pin_drive = latched & is_eprom(boot_mode) & ctrl[`BMS_CTRL_MASTER]; // RL4
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_memory_select_oe <= 1'b0;
    end else begin
      boot_memory_select_oe <= pin_drive; // RL5
    end
  end

  // idles high so an enabled driver never glitches the eprom select on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_memory_select_out <= 1'b1;
    end else begin
      boot_memory_select_out <= ~ctrl[`BMS_CTRL_CS]; // RL2
    end
  end

  // one step per pclk while running: the core clock and the instruction rate are one
  always @* begin
    run_enable  = latched & ctrl[`BMS_CTRL_RUN];
    next_cycles = cycles;
    if (run_enable) begin
      next_cycles = cycles + 32'h00000001; // RL8
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_step <= 1'b0;
    end else begin
      instr_step <= run_enable; // RL8
    end
  end

  // the counter wraps silently; software must read it often enough
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycles <= `BMS_ZERO32;
    end else begin
      cycles <= next_cycles;
    end
  end

  always @* begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      next_ctrl = {29'h00000000, pwdata[2:0]};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `BMS_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always @* begin
    next_prdata = `BMS_ZERO32;
    next_slverr = 1'b0;
    case (paddr)
      `BMS_ADDR_CTRL: begin
        next_prdata = ctrl;
      end
      `BMS_ADDR_STATUS: begin
        next_prdata[`BMS_ST_MODE_LSB+2:`BMS_ST_MODE_LSB] = boot_mode;
        next_prdata[`BMS_ST_LATCHED]  = latched;
        next_prdata[`BMS_ST_OE]       = boot_memory_select_oe;
        next_prdata[`BMS_ST_EXTMEM]   = run_external;
        next_prdata[`BMS_ST_WIDTH8]   = boot_from_eprom;
        next_prdata[`BMS_ST_LINKPORT] = boot_from_link;
      end
      `BMS_ADDR_STRAP: begin
        next_prdata[2:0] = strap_bits;
      end
      `BMS_ADDR_CYCLES: begin
        next_prdata = cycles;
      end
      default: begin
        next_slverr = 1'b1;
      end
    endcase
  end

  // answer is registered at the setup edge, so pready stands in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup & next_slverr;
    end
  end

  // read data is zero outside the answer cycle so stale words never leak
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `BMS_ZERO32;
    end else if (setup & ~pwrite) begin
      prdata <= next_prdata;
    end else begin
      prdata <= `BMS_ZERO32;
    end
  end
endmodule

// ### test/bms_chk.sv
// assertion checker for the boot mode select block
`timescale 1ns/10ps
module bms_chk (
  input logic       pclk,
  input logic       presetn,
  input logic       psel,
  input logic       penable,
  input logic       pready,
  input logic       eprom_boot_strap,
  input logic       link_boot_strap,
  input logic       boot_memory_select_in,
  input logic       boot_memory_select_oe,
  input logic [2:0] boot_mode,
  input logic       boot_from_eprom,
  input logic       run_external,
  input logic       instr_step
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       lat;
  logic [2:0] dec;
  // straps are taken at the first edge after release
  always @(posedge pclk or negedge presetn)
    if (!presetn) lat <= 1'b0;
    else lat <= 1'b1;
  assign dec = eprom_boot_strap ? (link_boot_strap ? 3'h4 : 3'h3) : link_boot_strap ?
    (boot_memory_select_in ? 3'h2 : 3'h4) : {2'h0, boot_memory_select_in};
  sequence s_setup;
    psel && !penable;
  endsequence
  a_mode_decode: assert property (lat |-> boot_mode == dec) else $error("mode");
  a_mode_held: assert property (lat |=> $stable(boot_mode)) else $error("held");
  a_oe_eprom: assert property (boot_memory_select_oe |-> boot_mode == 3'h3) else $error("oe");
  a_eprom_flag: assert property ($past(lat) |-> boot_from_eprom == (boot_mode == 3'h3))
    else $error("eprom");
  a_no_boot: assert property ($past(lat) |-> run_external == (boot_mode == 3'h0))
    else $error("ext");
  a_step_latched: assert property (instr_step |-> lat) else $error("step");
  a_apb_answer: assert property (s_setup |=> pready) else $error("ready");
  a_ready_once: assert property (pready |=> !pready) else $error("ready long");
endmodule
bind bms_top bms_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .eprom_boot_strap,
  .link_boot_strap, .boot_memory_select_in, .boot_memory_select_oe, .boot_mode,
  .boot_from_eprom, .run_external, .instr_step);

// ### test/bms_far.sv
// far side model: hardwired straps and the shared select pin
`timescale 1ns/10ps
module bms_far (
  input  logic [2:0] strap,
  input  logic       cs_out,
  input  logic       cs_oe,
  output logic       eprom_lvl,
  output logic       link_lvl,
  output logic       pin
);
  assign eprom_lvl = strap[2];
  assign link_lvl  = strap[1];
  // undriven pin falls back to its wired level
  assign pin = cs_oe ? cs_out : strap[0];
endmodule

// ### test/boot_mode_select_tb.sv
// self-checking bench for the boot mode select block
`timescale 1ns/10ps
module boot_mode_select_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, v, r;
  logic [2:0]  strap, boot_mode;
  logic        eprom_boot_strap, link_boot_strap, boot_memory_select_in, instr_step;
  logic        boot_memory_select_out, boot_memory_select_oe, run_external;
  logic        boot_from_eprom, boot_from_link, boot_from_host;
  int          num_errors, n_compared, i, m;
  bms_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .eprom_boot_strap, .link_boot_strap, .boot_memory_select_in,
    .boot_memory_select_out, .boot_memory_select_oe, .boot_mode, .boot_from_eprom,
    .boot_from_link, .boot_from_host, .run_external, .instr_step);
  bms_far far (.strap, .cs_out(boot_memory_select_out), .cs_oe(boot_memory_select_oe),
    .eprom_lvl(eprom_boot_strap), .link_lvl(link_boot_strap), .pin(boot_memory_select_in));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int mdl(int s);
    if (s[2]) return s[1] ? 4 : 3;
    if (s[1]) return s[0] ? 2 : 4;
    return s[0];
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    wrap_up;
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    strap = 3'h0;
    seed = 32'h91DB;
    for (i = 0; i < 8; i++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      strap <= i[2:0];
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      m = mdl(i);
      repeat (3) @(posedge pclk);
      chk(boot_mode, m);
      chk({boot_from_eprom, boot_from_link, boot_from_host, run_external},
        {m == 3, m == 2, m == 1, m == 0});
      apb(1'b0, 12'h008, 32'h0);
      chk(r[2:0], i);
      apb(1'b0, 12'h004, 32'h0);
      chk(r, {23'h0, m == 2, m == 3, m == 0, 1'b0, 1'b1, 1'b0, m[2:0]});
      v = xs();
      v[0] = i[0];
      apb(1'b1, 12'h000, v);
      apb(1'b0, 12'h000, 32'h0);
      chk(r, v & 32'h7);
      chk({boot_memory_select_oe, boot_memory_select_out, instr_step},
        {m == 3 && v[0], !v[1], v[2]});
      apb(1'b0, 12'h010, v);
      chk({e, r[30:0]}, {1'b1, 31'h0});
      $display("case %0d done", i);
    end
    wrap_up;
  end
endmodule
